// File: design/pbo_cfg.svh
// Constants and rule summary for the port B override block
// How it works
// RQ1: Slave mode forces clock pin to input
// RQ2: Master mode forces data-in/out pin to input
// RQ3: Slave mode forces master-out pin to input
// RQ4: Slave mode forces select pin to input
// RQ5: Slave active only while select held low
// RQ6: Forced inputs keep pull-up from output bit
// RQ7: Route master/slave data onto correct pins
// RQ8: Bit 2 carries compare B when output
// RQ9: Bit 1 carries compare A when output
// RQ10: Bit 0 input feeds capture, no overrides
// RQ11: Fuse drives divided clock on bit 0, even reset
// RQ12: Mask and group enable force input buffer on
// RQ13: Port C pin n is change source 8+n
// RQ14: Direction override picks driver enable
// RQ15: Value override replaces output bit
// RQ16: Input-enable override beats sleep state
// RQ17: Overrides combinational, no added cycles; code registers pad controls, landing one clock-enabled edge later
`ifndef PBO_CFG_SVH
`define PBO_CFG_SVH
//----------------------------------------
// Pin positions
//----------------------------------------
`define PBO_NPINS 6
`define PBO_BIT_SCK 5
`define PBO_BIT_MISO 4
`define PBO_BIT_MOSI 3
`define PBO_BIT_SEL 2
`define PBO_BIT_CMPA 1
`define PBO_BIT_CAP 0
`define PBO_PC_BASE 4'h8
`define PBO_RST_OUT 6'h00
`define PBO_RST_PC 8'h00
`define PBO_RST_BIT 1'h0
`define PBO_CLK_PIN 6'h01
`define PBO_ALL_ON 6'h3f
`endif

// File: design/pbo_pkg.sv
// Types for the port B override block
package pbo_pkg;
   typedef logic [5:0] pbo_pins_t; // One bit per port B pin 5..0
   typedef logic [7:0] pbo_pcpins_t; // Port C pin vector
endpackage

// File: design/pbo_pad.sv
// Generic override pad cell: applies override signals to one pin
`timescale 1ns/1ps
module pbo_pad (
   input wire logic dir_bit_i,
   input wire logic out_bit_i,
   input wire logic pud_i,
   input wire logic sleep_i,
   input wire logic dir_override_en_i,
   input wire logic dir_override_val_i,
   input wire logic value_override_en_i,
   input wire logic value_override_val_i,
   input wire logic pullup_override_en_i,
   input wire logic pullup_override_val_i,
   input wire logic input_enable_override_en_i,
   input wire logic input_enable_override_val_i,
   output logic drv_en_o,
   output logic drv_val_o,
   output logic pullup_o,
   output logic in_en_o
);
   //----------------------------------------
   // Override selection
   //----------------------------------------
   wire drv_en = dir_override_en_i ? dir_override_val_i : dir_bit_i; // [RQ14]
   wire normal_pu = out_bit_i & ~dir_bit_i & ~pud_i;
   assign drv_en_o = drv_en;
   // Value override only matters when driving
   assign drv_val_o = value_override_en_i ? value_override_val_i : out_bit_i; // [RQ15]
   // Pull-up only while not driving
   assign pullup_o = ~drv_en & (pullup_override_en_i ? pullup_override_val_i : normal_pu);
   // Override ignores sleep state
   assign in_en_o = input_enable_override_en_i ? input_enable_override_val_i : ~sleep_i; // [RQ16]
endmodule // pbo_pad

// File: design/pbo_top.sv
// Port B pins 5..0 alternate function override logic
`timescale 1ns/1ps
`include "pbo_cfg.svh"
module pbo_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire pbo_pkg::pbo_pins_t portb_dir_i,
   input wire pbo_pkg::pbo_pins_t portb_out_i,
   input wire pbo_pkg::pbo_pins_t pad_in_i,
   input wire logic global_pullup_disable_i,
   input wire logic sleep_i,
   input wire logic serial_if_enable_i,
   input wire logic serial_master_select_i,
   input wire logic sck_out_i,
   input wire logic spi_master_out_i,
   input wire logic spi_slave_out_i,
   input wire logic timer16_compare_a_en_i,
   input wire logic timer16_compare_a_out_i,
   input wire logic timer16_compare_b_en_i,
   input wire logic timer16_compare_b_out_i,
   input wire logic clock_out_fuse_i,
   input wire logic divided_clock_i,
   input wire pbo_pkg::pbo_pins_t pin_change_mask_i,
   input wire logic pin_change_group0_enable_i,
   input wire pbo_pkg::pbo_pcpins_t portc_in_i,
   output pbo_pkg::pbo_pins_t pad_oe_o,
   output pbo_pkg::pbo_pins_t pad_out_o,
   output pbo_pkg::pbo_pins_t pad_pullup_o,
   output pbo_pkg::pbo_pins_t pad_in_en_o,
   output pbo_pkg::pbo_pins_t pin_change_src_o,
   output logic [15:8] pin_change_src_c_o,
   output logic spi_sck_in_o,
   output logic spi_data_in_o,
   output logic spi_slave_active_o,
   output logic timer16_capture_in_o
);
   import pbo_pkg::*;

   //----------------------------------------
   // Pad input synchronisers
   //----------------------------------------
   pbo_pins_t in_s1_r; // First stage, read only by second
   pbo_pins_t in_s2_r; // Safe sampled pad levels
   pbo_pcpins_t pc_s1_r; // Port C first stage
   pbo_pcpins_t pc_s2_r; // Port C second stage

   // Two-flop capture of the pins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         in_s1_r <= `PBO_RST_OUT;
         in_s2_r <= `PBO_RST_OUT;
         pc_s1_r <= `PBO_RST_PC;
         pc_s2_r <= `PBO_RST_PC;
      end else if (ce_i) begin
         in_s1_r <= pad_in_i;
         in_s2_r <= in_s1_r;
         pc_s1_r <= portc_in_i;
         pc_s2_r <= pc_s1_r;
      end
   end

   //----------------------------------------
   // Override decode
   //----------------------------------------
   wire spi_mst = serial_if_enable_i & serial_master_select_i; // Master mode
   wire spi_slv = serial_if_enable_i & ~serial_master_select_i; // Slave mode
   pbo_pins_t dir_override_en; // Direction override enables
   pbo_pins_t dir_override_val; // Direction override values
   pbo_pins_t value_override_en; // Value override enables
   pbo_pins_t value_override_val; // Value override values
   pbo_pins_t pullup_override_en; // Pull-up override enables
   pbo_pins_t pullup_override_val; // Pull-up override values
   pbo_pins_t input_enable_override_en; // Input enable override enables

   // Forced-input pins per mode
   assign dir_override_en = {spi_slv, spi_mst, spi_slv, spi_slv, 1'h0, 1'h0}; // [RQ1] [RQ2] [RQ3] [RQ4]
   assign dir_override_val = `PBO_RST_OUT; // Forced pins become inputs
   // Pull-up of forced input follows output bit
   assign pullup_override_en = dir_override_en; // [RQ6]
   assign pullup_override_val = portb_out_i & {`PBO_NPINS{~global_pullup_disable_i}}; // [RQ6]
   // Output value routing
   assign value_override_en = {spi_mst, spi_slv, spi_mst, timer16_compare_b_en_i,
                  timer16_compare_a_en_i, 1'h0}; // [RQ7] [RQ8] [RQ9] [RQ10]
   assign value_override_val = {sck_out_i, spi_slave_out_i, spi_master_out_i, timer16_compare_b_out_i,
                  timer16_compare_a_out_i, 1'h0}; // [RQ7] [RQ8] [RQ9]
   // Forced input buffer for enabled change sources
   assign input_enable_override_en = pin_change_mask_i & {`PBO_NPINS{pin_change_group0_enable_i}}; // [RQ12]

   //----------------------------------------
   // Pad cells
   //----------------------------------------
   pbo_pins_t oe_w; // Driver enables
   pbo_pins_t val_w; // Driver values
   pbo_pins_t pu_w; // Pull-ups
   pbo_pins_t ie_w; // Input enables

   genvar g;
   generate
      for (g = 0; g < `PBO_NPINS; g++) begin : g_pad
         pbo_pad u_pad (
            .dir_bit_i(portb_dir_i[g]),
            .out_bit_i(portb_out_i[g]),
            .pud_i(global_pullup_disable_i),
            .sleep_i(sleep_i),
            .dir_override_en_i(dir_override_en[g]),
            .dir_override_val_i(dir_override_val[g]),
            .value_override_en_i(value_override_en[g]),
            .value_override_val_i(value_override_val[g]),
            .pullup_override_en_i(pullup_override_en[g]),
            .pullup_override_val_i(pullup_override_val[g]),
            .input_enable_override_en_i(input_enable_override_en[g]),
            .input_enable_override_val_i(1'h1),
            .drv_en_o(oe_w[g]),
            .drv_val_o(val_w[g]),
            .pullup_o(pu_w[g]),
            .in_en_o(ie_w[g])
         );
      end
   endgenerate

   //----------------------------------------
   // Clock output on bit 0
   //----------------------------------------
   // Fuse wins over port bits, also in reset
   pbo_pins_t oe_fin; // Final driver enables
   pbo_pins_t val_fin; // Final driver values
   pbo_pins_t pu_fin; // Final pull-ups
   pbo_pins_t clk_sel; // Marks the clock output pin while fused
   pbo_pins_t clk_val; // Divided clock placed on that pin
   assign clk_sel = `PBO_CLK_PIN & {`PBO_NPINS{clock_out_fuse_i}}; // [RQ11]
   assign clk_val = clk_sel & {`PBO_NPINS{divided_clock_i}}; // [RQ11]
   assign oe_fin = oe_w | clk_sel; // [RQ11]
   assign val_fin = (val_w & ~clk_sel) | clk_val; // [RQ11]
   // A pin that drives the clock needs no pull-up
   assign pu_fin = pu_w & ~clk_sel;

   //----------------------------------------
   // Output registers
   //----------------------------------------
   // Pad controls, registered on each clock-enabled cycle so change lands one edge later
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         // Clock pin keeps driving through reset
         pad_oe_o <= clk_sel; // [RQ11]
         pad_out_o <= clk_val; // [RQ11]
         pad_pullup_o <= `PBO_RST_OUT;
         pad_in_en_o <= `PBO_RST_OUT;
      end else if (ce_i) begin
         pad_oe_o <= oe_fin; // [RQ17]
         pad_out_o <= val_fin; // [RQ17]
         pad_pullup_o <= pu_fin;
         pad_in_en_o <= ie_w;
      end
   end

   // Digital inputs to peripherals and change logic
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_change_src_o <= `PBO_RST_OUT;
         pin_change_src_c_o <= `PBO_RST_PC;
         spi_sck_in_o <= `PBO_RST_BIT;
         spi_data_in_o <= `PBO_RST_BIT;
         spi_slave_active_o <= `PBO_RST_BIT;
         timer16_capture_in_o <= `PBO_RST_BIT;
      end else if (ce_i) begin
         pin_change_src_o <= in_s2_r & ie_w; // [RQ12]
         pin_change_src_c_o <= pc_s2_r; // [RQ13]
         spi_sck_in_o <= in_s2_r[`PBO_BIT_SCK];
         // Master reads data-in pin, slave reads master-out pin
         spi_data_in_o <= spi_mst ? in_s2_r[`PBO_BIT_MISO] : in_s2_r[`PBO_BIT_MOSI]; // [RQ7]
         spi_slave_active_o <= spi_slv & ~in_s2_r[`PBO_BIT_SEL]; // [RQ5]
         timer16_capture_in_o <= in_s2_r[`PBO_BIT_CAP]; // [RQ10]
      end
   end

   //----------------------------------------
   // Assertions
   //----------------------------------------
   // Clock pin is an input whenever the interface is a slave
   a_sck_slave_in: assert property ( // [RQ1]
      @(posedge clk_i) disable iff (rst_i)
      ce_i && spi_slv && !clock_out_fuse_i |=> !pad_oe_o[`PBO_BIT_SCK])
      else $error("clock pin driven in slave mode");

   // Clock pin follows its direction bit as master
   a_sck_master_dir: assert property ( // [RQ1]
      @(posedge clk_i) disable iff (rst_i)
      ce_i && spi_mst |=> pad_oe_o[`PBO_BIT_SCK] == $past(portb_dir_i[`PBO_BIT_SCK]))
      else $error("clock pin direction wrong in master mode");

   // Data-in pin is an input whenever the interface is master
   a_miso_master_in: assert property ( // [RQ2]
      @(posedge clk_i) disable iff (rst_i)
      ce_i && spi_mst |=> !pad_oe_o[`PBO_BIT_MISO])
      else $error("data-in pin driven in master mode");

   // Data-in pin follows its direction bit as slave
   a_miso_slave_dir: assert property ( // [RQ2]
      @(posedge clk_i) disable iff (rst_i)
      ce_i && spi_slv |=> pad_oe_o[`PBO_BIT_MISO] == $past(portb_dir_i[`PBO_BIT_MISO]))
      else $error("data-in pin direction wrong in slave mode");

   // Master-out pin is an input as slave
   a_mosi_slave_in: assert property ( // [RQ3]
      @(posedge clk_i) disable iff (rst_i)
      ce_i && spi_slv |=> !pad_oe_o[`PBO_BIT_MOSI])
      else $error("master-out pin driven in slave mode");

   // Select pin is an input as slave
   a_sel_slave_in: assert property ( // [RQ4]
      @(posedge clk_i) disable iff (rst_i)
      ce_i && spi_slv |=> !pad_oe_o[`PBO_BIT_SEL])
      else $error("select pin driven in slave mode");

   // Slave active only after a sampled low select; frozen cycles skipped
   a_slave_active_sel: assert property ( // [RQ5]
      @(posedge clk_i) disable iff (rst_i)
      $past(ce_i) && spi_slave_active_o |-> $past(spi_slv) && !$past(in_s2_r[`PBO_BIT_SEL]))
      else $error("slave active without select low");

   // Forced input keeps the pull-up from its output bit
   a_pullup_forced: assert property ( // [RQ6]
      @(posedge clk_i) disable iff (rst_i)
      ce_i && spi_slv && portb_out_i[`PBO_BIT_MOSI] && !global_pullup_disable_i
      |=> pad_pullup_o[`PBO_BIT_MOSI])
      else $error("forced input lost pull-up");

   // No pin has its pull-up on while it drives
   a_pullup_driven: assert property ( // [RQ6]
      @(posedge clk_i) disable iff (rst_i)
      ce_i |=> (pad_pullup_o & pad_oe_o) == `PBO_RST_OUT)
      else $error("pull-up on a driven pin");

   // Master reads the data-in pin, slave the master-out pin
   a_data_in_route: assert property ( // [RQ7]
      @(posedge clk_i) disable iff (rst_i)
      ce_i |=> spi_data_in_o == ($past(spi_mst) ? $past(in_s2_r[`PBO_BIT_MISO])
                                                : $past(in_s2_r[`PBO_BIT_MOSI])))
      else $error("serial data input from wrong pin");

   // Slave output lands on the data-in pin
   a_miso_slave_out: assert property ( // [RQ7]
      @(posedge clk_i) disable iff (rst_i)
      ce_i && spi_slv |=> pad_out_o[`PBO_BIT_MISO] == $past(spi_slave_out_i))
      else $error("slave output not on data pin");

   // Compare B on the select pin when set to output
   a_cmpb_route: assert property ( // [RQ8]
      @(posedge clk_i) disable iff (rst_i)
      ce_i && !serial_if_enable_i && portb_dir_i[`PBO_BIT_SEL] && timer16_compare_b_en_i
      |=> pad_oe_o[`PBO_BIT_SEL] && pad_out_o[`PBO_BIT_SEL] == $past(timer16_compare_b_out_i))
      else $error("compare B not on pin");

   // Compare A on bit 1 when set to output
   a_cmpa_route: assert property ( // [RQ9]
      @(posedge clk_i) disable iff (rst_i)
      ce_i && portb_dir_i[`PBO_BIT_CMPA] && timer16_compare_a_en_i
      |=> pad_out_o[`PBO_BIT_CMPA] == $past(timer16_compare_a_out_i))
      else $error("compare A not on pin");

   // Capture input taken from the synchronised bit 0 level
   a_cap_route: assert property ( // [RQ10]
      @(posedge clk_i) disable iff (rst_i)
      ce_i |=> timer16_capture_in_o == $past(in_s2_r[`PBO_BIT_CAP]))
      else $error("capture input from wrong pin");

   // Fuse drives the divided clock, in reset as well
   a_clkout_fuse: assert property ( // [RQ11]
      @(posedge clk_i)
      (ce_i || rst_i) && clock_out_fuse_i
      |=> pad_oe_o[`PBO_BIT_CAP] && pad_out_o[`PBO_BIT_CAP] == $past(divided_clock_i))
      else $error("clock output not driven");

   // Every masked change source keeps its input buffer on while the group is enabled
   a_pc_input_en: assert property ( // [RQ12]
      @(posedge clk_i) disable iff (rst_i)
      ce_i && pin_change_group0_enable_i
      |=> (pad_in_en_o & $past(pin_change_mask_i)) == $past(pin_change_mask_i))
      else $error("change source input disabled");

   // Port C pin n reaches change source 8 plus n
   a_pc_c_map: assert property ( // [RQ13]
      @(posedge clk_i) disable iff (rst_i)
      ce_i |=> pin_change_src_c_o == $past(pc_s2_r))
      else $error("port C change source misnumbered");

   // With no overrides each driver follows its direction bit
   a_dir_follow: assert property ( // [RQ14]
      @(posedge clk_i) disable iff (rst_i)
      ce_i && !serial_if_enable_i && !clock_out_fuse_i |=> pad_oe_o == $past(portb_dir_i))
      else $error("driver enable not from direction bits");

   // Master clock output replaces the port bit
   a_sck_value: assert property ( // [RQ15]
      @(posedge clk_i) disable iff (rst_i)
      ce_i && spi_mst |=> pad_out_o[`PBO_BIT_SCK] == $past(sck_out_i))
      else $error("serial clock value not on pin");

   // Awake, every input buffer is on
   a_awake_input: assert property ( // [RQ16]
      @(posedge clk_i) disable iff (rst_i)
      ce_i && !sleep_i |=> pad_in_en_o == `PBO_ALL_ON)
      else $error("input buffer off while awake");

   // Pad controls only move on enabled edges
   a_freeze_hold: assert property ( // [RQ17]
      @(posedge clk_i) disable iff (rst_i)
      !ce_i |=> $stable(pad_oe_o) && $stable(pad_out_o))
      else $error("pad controls moved while frozen");

   c_slave_sel: cover property (@(posedge clk_i) spi_slave_active_o);
   c_master: cover property (@(posedge clk_i) ce_i && spi_mst);
   c_clkout: cover property (@(posedge clk_i) rst_i && clock_out_fuse_i);
   c_compare_b: cover property (@(posedge clk_i)
      ce_i && timer16_compare_b_en_i && portb_dir_i[`PBO_BIT_SEL]);
endmodule // pbo_top

// File: testbench/pbo_periph_model.sv
// Peripheral-side model: SPI, timer compare and clock divider outputs
`timescale 1ns/1ps
module pbo_periph_model (
   input wire logic clk_i,
   input wire logic step_i,
   output logic [5:0] per_o
);
   //--------------------
   // Output pattern
   //--------------------
   logic [7:0] lfsr_r = 8'h5a; // Pattern state
   // New values only on step, held steady between steps
   always_ff @(posedge clk_i) begin
      if (step_i) begin
         lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
      end
   end
   // Bits: sck, master out, slave out, cmp a, cmp b, divided clock
   assign per_o = lfsr_r[5:0];
endmodule // pbo_periph_model

// File: testbench/pbo_top_bench.sv
// Self-checking bench for the port B override block
`timescale 1ns/1ps
module pbo_top_bench;
   import pbo_pkg::*;
   //--------------------
   // Stimulus and results
   //--------------------
   logic clk_i = 1'h0;
   logic rst_i = 1'h1;
   logic ce_i = 1'h1;
   pbo_pins_t dir = 6'h00, out = 6'h00, pin = 6'h00, mask = 6'h00;
   logic global_pullup_disable = 1'h0, slp = 1'h0, en = 1'h0, mst = 1'h0, cae = 1'h0;
   logic cbe = 1'h0, fuse = 1'h1, grp = 1'h0, step = 1'h0;
   pbo_pcpins_t pc = 8'h00;
   logic [5:0] per;
   pbo_pins_t oe, po, pu, ie, pcs;
   logic [15:8] pcc;
   logic sck_in, din, sact, cap;
   logic [23:0] sv;
   int miscompares = 0, check_count = 0, cyc = 0, seed = 37;
   always #5 clk_i = ~clk_i;
   pbo_top i_pbo_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .portb_dir_i(dir),
      .portb_out_i(out), .pad_in_i(pin), .global_pullup_disable_i(global_pullup_disable), .sleep_i(slp),
      .serial_if_enable_i(en), .serial_master_select_i(mst), .sck_out_i(per[0]),
      .spi_master_out_i(per[1]), .spi_slave_out_i(per[2]), .timer16_compare_a_en_i(cae),
      .timer16_compare_a_out_i(per[3]), .timer16_compare_b_en_i(cbe),
      .timer16_compare_b_out_i(per[4]), .clock_out_fuse_i(fuse), .divided_clock_i(per[5]),
      .pin_change_mask_i(mask), .pin_change_group0_enable_i(grp), .portc_in_i(pc),
      .pad_oe_o(oe), .pad_out_o(po), .pad_pullup_o(pu), .pad_in_en_o(ie),
      .pin_change_src_o(pcs), .pin_change_src_c_o(pcc), .spi_sck_in_o(sck_in),
      .spi_data_in_o(din), .spi_slave_active_o(sact), .timer16_capture_in_o(cap));
   pbo_periph_model i_pbo_periph_model (.clk_i(clk_i), .step_i(step), .per_o(per));
   //--------------------
   // Checking and closing
   //--------------------
   // Compare one value, count and report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Counts, verdict and end of run
   task automatic close_out;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Hang guard
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         close_out;
      end
   end
   //--------------------
   // Tests
   //--------------------
   // Reset with a chosen fuse, outputs cleared except clock pin
   task automatic do_reset(input int n, input logic f);
      @(posedge clk_i);
      rst_i <= 1'h1;
      fuse <= f;
      repeat (n) @(posedge clk_i);
      #1;
      chk({oe, po, pu, ie, pcs}, {5'h00, f, 5'h00, f & per[5], 18'h00000});
      @(posedge clk_i);
      rst_i <= 1'h0;
      $display("reset test done");
   endtask
   // Random inputs, held still; model compare unless clock enable low
   task automatic apply(input logic c);
      int r;
      int q;
      logic sl;
      logic ms;
      pbo_pins_t e_oe, e_po, e_ie;
      @(posedge clk_i);
      step <= 1'h1;
      @(posedge clk_i);
      r = $random(seed);
      q = $random(seed);
      step <= 1'h0;
      ce_i <= c;
      dir <= r[5:0];
      out <= r[11:6];
      pin <= r[17:12]; // Pad levels for all six pins, select pin among them
      mask <= r[23:18];
      pc <= r[31:24];
      {fuse, grp, cbe, cae, mst, en, slp, global_pullup_disable} <= q[7:0];
      @(posedge clk_i);
      #1;
      sl = en & ~mst;
      ms = en & mst;
      e_oe = dir & {~sl, ~ms, ~sl, ~sl, 2'h3};
      e_oe[0] = dir[0] | fuse;
      e_po = {ms ? per[0] : out[5], sl ? per[2] : out[4], ms ? per[1] : out[3],
         cbe ? per[4] : out[2], cae ? per[3] : out[1], fuse ? per[5] : out[0]};
      e_ie = (mask & {6{grp}}) | {6{~slp}};
      if (c) begin
         chk(oe, e_oe);
         chk(po & e_oe, e_po & e_oe);
         chk(pu, ~e_oe & out & {6{~global_pullup_disable}});
         chk(ie, e_ie);
      end
      repeat (3) @(posedge clk_i);
      #1;
      if (c) begin
         chk(pcs, pin & e_ie);
         chk(pcc, pc);
         chk({sck_in, cap, sact}, {pin[5], pin[0], sl & ~pin[2]});
         if (en) begin
            chk(din, mst ? pin[4] : pin[3]);
         end
      end
   endtask
   // Main sequence
   initial begin
      do_reset(14, 1'h1);
      repeat (300) apply(1'h1);
      $display("random test done");
      sv = {oe, po, pu, ie};
      apply(1'h0);
      chk({oe, po, pu, ie}, sv);
      $display("freeze test done");
      do_reset(3, 1'h0);
      repeat (40) apply(1'h1);
      $display("second run done");
      close_out;
   end
endmodule // pbo_top_bench
